// file: core/idle_power_cfg.svh
// Offsets, field positions, reset values and widths of the idle power control block
`ifndef IDLE_POWER_CFG_SVH
`define IDLE_POWER_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define STATUS_IDX          16'h0002
`define CONFIG_IDX          16'h0001
`define MASK_IDX            16'h9400

// Configuration register fields
`define CFG_CORE_BIT        0
`define CFG_MASTERS_BIT     1
`define CFG_IBUF_BIT        2
`define CFG_UNITS_BIT       3
`define CFG_EXT_MEM_SLEEP_MASK_BIT        4
`define CFG_IOPORT_BIT      5
`define CFG_MASTER_PORT_BIT       6
`define CFG_FPORT_BIT       7
`define CFG_CLKGEN_BIT      8
`define CFG_EXTCLK_BIT      9
`define CFG_WR_MASK         16'h03FF
`define CFG_RESET           16'h0000

// Status register fields
`define ST_CORE_BIT         0
`define ST_MASTERS_BIT      1
`define ST_IBUF_BIT         2
`define ST_UNITS_BIT        3
`define ST_CLKGEN_BIT       4
`define ST_EXT_MEM_SLEEP_MASK_BIT         5
`define ST_IOPORT_BIT       6
`define ST_MASTER_PORT_BIT        7
`define ST_FPORT_BIT        8
`define ST_WIDTH            9

// Unit mask: bits 13..0 writable, 15..14 read as zero
`define MASK_WIDTH          14
`define MASK_RESET          14'h0000

// Order of the domain request vector
`define DOM_CORE            0
`define DOM_MASTERS         1
`define DOM_IBUF            2
`define DOM_CLKGEN          3
`define DOM_EXT_MEM_SLEEP_MASK            4
`define DOM_IOPORT          5
`define DOM_MASTER_PORT           6
`define DOM_FPORT           7
`define DOM_WIDTH           8

`endif

// file: core/idle_power_pkg.sv
// Types of the idle power control block
`default_nettype none
`include "idle_power_cfg.svh"
package idle_power_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTER,
    ST_ASLEEP,
    ST_LEAVE
  } sleep_fsm_t;

  typedef struct packed {
    sleep_fsm_t                fsm;
    logic [15:0]               cfg;
    logic [`MASK_WIDTH-1:0]    mask;
    logic [`DOM_WIDTH-1:0]     dom_req;
    logic [`MASK_WIDTH-1:0]    unit_req;
    logic [`ST_WIDTH-1:0]      status;
    logic [31:0]               rdata;
    logic                      ready;
    logic                      slverr;
    logic                      bus_err;
  } ctrl_state_t;

endpackage : idle_power_pkg
`default_nettype wire

// file: core/idle_domain_power_control.sv
// Idle power-down controller with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "idle_power_cfg.svh"

module idle_domain_power_control #(
  parameter int ADDR_W = 18
) (
  input  wire logic                   clk_i,               // System clock, 25 MHz
  input  wire logic                   reset_i,             // Asynchronous reset, active high
  input  wire logic                   ce_i,                // Clock enable, freezes state when low
  input  wire logic                   psel,                // APB select
  input  wire logic                   penable,             // APB access phase
  input  wire logic                   pwrite,              // APB direction, high is write
  input  wire logic [ADDR_W-1:0]      paddr,               // APB byte address
  input  wire logic [31:0]            pwdata,              // APB write data
  output      logic [31:0]            prdata,              // APB read data
  output      logic                   pready,              // APB ready
  output      logic                   pslverr,             // APB error, unmapped address
  input  wire logic                   idle_strobe_i,       // Idle instruction executed, one cycle
  input  wire logic                   wake_i,              // Wake event for the core domains
  input  wire logic                   core_stopped_i,      // Core acknowledges stop
  input  wire logic                   masters_stopped_i,   // DMA and host port stopped
  input  wire logic                   ibuf_stopped_i,      // Instruction buffer stopped
  input  wire logic                   clkgen_stopped_i,    // Clock generator stopped
  input  wire logic                   ext_mem_sleep_mask_stopped_i,      // External memory interface stopped
  input  wire logic                   io_port_stopped_i,   // I/O space port stopped
  input  wire logic                   master_port_stopped_i,     // Bus master port stopped
  input  wire logic                   fport_stopped_i,     // Fetch port stopped
  input  wire logic [`MASK_WIDTH-1:0] unit_stopped_i,      // Attached units stopped, mask order
  output      logic                   core_sleep_req,      // Stop request to the core
  output      logic                   bus_masters_sleep_req, // Stop request to DMA and host port
  output      logic                   instr_buffer_sleep_req, // Stop request to instr buffer
  output      logic                   clockgen_sleep_req,  // Stop request to clock generator
  output      logic                   ext_mem_if_sleep_o,  // Stop request to memory interface
  output      logic                   io_space_port_sleep_o, // Stop request to I/O space port
  output      logic                   master_port_sleep_o, // Stop request to bus master port
  output      logic                   fetch_port_sleep_o,  // Stop request to fetch port
  output      logic [`MASK_WIDTH-1:0] unit_sleep_o,        // Stop requests to attached units
  output      logic                   asleep_o,            // All requested core domains stopped
  output      logic                   bus_error_o          // Refused idle, one-cycle pulse
);
  import idle_power_pkg::*;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic                   acc_phase;
  logic                   wr_commit;
  logic                   hit_status;
  logic                   hit_config;
  logic                   hit_mask;
  logic [`DOM_WIDTH-1:0]  dom_stopped;
  logic [`DOM_WIDTH-1:0]  cfg_dom;
  logic                   clk_combo_bad;

  // True when the byte address selects the register with the given index
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    logic [ADDR_W+1:0] byte_addr;
    byte_addr = (ADDR_W+2)'({idx, 2'b00});
    addr_hit  = ({2'b00, addr} == byte_addr);
  endfunction : addr_hit

  // Zero-extends a 16-bit register image onto the 32-bit bus
  function automatic logic [31:0] widen(input logic [15:0] val);
    widen = {16'h0000, val};
  endfunction : widen

  // Address decode
  assign hit_status = addr_hit(paddr, `STATUS_IDX);
  assign hit_config = addr_hit(paddr, `CONFIG_IDX);
  assign hit_mask   = addr_hit(paddr, `MASK_IDX);
  assign acc_phase  = psel & penable;
  assign wr_commit  = acc_phase & s_q.ready & pwrite & ~s_q.slverr;

  // Acknowledges gathered in domain order
  always_comb begin
    dom_stopped               = '0;
    dom_stopped[`DOM_CORE]    = core_stopped_i;
    dom_stopped[`DOM_MASTERS] = masters_stopped_i;
    dom_stopped[`DOM_IBUF]    = ibuf_stopped_i;
    dom_stopped[`DOM_CLKGEN]  = clkgen_stopped_i;
    dom_stopped[`DOM_EXT_MEM_SLEEP_MASK]    = ext_mem_sleep_mask_stopped_i;
    dom_stopped[`DOM_IOPORT]  = io_port_stopped_i;
    dom_stopped[`DOM_MASTER_PORT]   = master_port_stopped_i;
    dom_stopped[`DOM_FPORT]   = fport_stopped_i;
  end

  // Configuration bits turned into domain requests
  always_comb begin
    cfg_dom               = '0;
    cfg_dom[`DOM_CORE]    = s_q.cfg[`CFG_CORE_BIT];
    cfg_dom[`DOM_MASTERS] = s_q.cfg[`CFG_MASTERS_BIT];
    cfg_dom[`DOM_IBUF]    = s_q.cfg[`CFG_IBUF_BIT];
    cfg_dom[`DOM_CLKGEN]  = s_q.cfg[`CFG_CLKGEN_BIT];
    cfg_dom[`DOM_EXT_MEM_SLEEP_MASK]    = s_q.cfg[`CFG_EXT_MEM_SLEEP_MASK_BIT];
    cfg_dom[`DOM_IOPORT]  = s_q.cfg[`CFG_IOPORT_BIT];
    cfg_dom[`DOM_MASTER_PORT]   = s_q.cfg[`CFG_MASTER_PORT_BIT];
    cfg_dom[`DOM_FPORT]   = s_q.cfg[`CFG_FPORT_BIT];
  end

  // Clock generator stop is only legal with the external clock bit set and every other domain also requested
  assign clk_combo_bad = s_q.cfg[`CFG_CLKGEN_BIT] &
                         ~(s_q.cfg[`CFG_EXTCLK_BIT] & s_q.cfg[`CFG_CORE_BIT] &
                           s_q.cfg[`CFG_MASTERS_BIT] & s_q.cfg[`CFG_IBUF_BIT] &
                           s_q.cfg[`CFG_EXT_MEM_SLEEP_MASK_BIT] & s_q.cfg[`CFG_IOPORT_BIT] &
                           s_q.cfg[`CFG_MASTER_PORT_BIT] & s_q.cfg[`CFG_FPORT_BIT]);

  // Next-state logic: bus slave, idle sequencer and status capture
  always_comb begin
    s_d         = s_q;
    s_d.bus_err = 1'b0;

    // Status follows the real acknowledges, never the requests
    s_d.status                 = '0;
    s_d.status[`ST_CORE_BIT]    = core_stopped_i;
    s_d.status[`ST_MASTERS_BIT] = masters_stopped_i;
    s_d.status[`ST_IBUF_BIT]    = ibuf_stopped_i;
    s_d.status[`ST_UNITS_BIT]   = |unit_stopped_i;
    s_d.status[`ST_CLKGEN_BIT]  = clkgen_stopped_i;
    s_d.status[`ST_EXT_MEM_SLEEP_MASK_BIT]    = ext_mem_sleep_mask_stopped_i;
    s_d.status[`ST_IOPORT_BIT]  = io_port_stopped_i;
    s_d.status[`ST_MASTER_PORT_BIT]   = master_port_stopped_i;
    s_d.status[`ST_FPORT_BIT]   = fport_stopped_i;

    // APB: one wait state, then registered answer
    if (acc_phase && !s_q.ready) begin
      s_d.ready  = 1'b1;
      s_d.slverr = ~(hit_status | hit_config | hit_mask);
      s_d.rdata  = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_status) begin
          s_d.rdata = widen({7'h00, s_q.status});
        end else if (hit_config) begin
          s_d.rdata = widen(s_q.cfg);
        end else if (hit_mask) begin
          s_d.rdata = widen({2'b00, s_q.mask});
        end
      end
    end else begin
      s_d.ready  = 1'b0;
      s_d.slverr = 1'b0;
    end

    // Register writes take effect at the completing edge; status ignores writes
    if (wr_commit) begin
      if (hit_config) begin
        s_d.cfg = pwdata[15:0] & `CFG_WR_MASK;
      end
      if (hit_mask) begin
        s_d.mask = pwdata[`MASK_WIDTH-1:0];
      end
    end

    // Idle sequencer
    case (s_q.fsm)
      ST_RUN: begin
        if (idle_strobe_i) begin
          if (clk_combo_bad) begin
            s_d.bus_err = 1'b1;
          end else begin
            s_d.dom_req = cfg_dom;
            if (s_q.cfg[`CFG_UNITS_BIT]) begin
              s_d.unit_req = s_q.mask;
            end else begin
              s_d.unit_req = '0;
            end
            s_d.fsm = ST_ENTER;
          end
        end
      end
      ST_ENTER: begin
        if (wake_i) begin
          s_d.dom_req = '0;
          s_d.fsm     = ST_LEAVE;
        end else if ((dom_stopped & s_q.dom_req) == s_q.dom_req) begin
          s_d.fsm = (s_q.dom_req == '0) ? ST_RUN : ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (wake_i) begin
          s_d.dom_req = '0;
          s_d.fsm     = ST_LEAVE;
        end
      end
      ST_LEAVE: begin
        if (dom_stopped == '0) begin
          s_d.fsm = ST_RUN;
        end
      end
      default: begin
        s_d.fsm     = ST_RUN;
        s_d.dom_req = '0;
      end
    endcase
  end

  // State register with clock enable
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q.fsm      <= ST_RUN;
      s_q.cfg      <= `CFG_RESET;
      s_q.mask     <= `MASK_RESET;
      s_q.dom_req  <= '0;
      s_q.unit_req <= '0;
      s_q.status   <= '0;
      s_q.rdata    <= 32'h0000_0000;
      s_q.ready    <= 1'b0;
      s_q.slverr   <= 1'b0;
      s_q.bus_err  <= 1'b0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign prdata                 = s_q.rdata;
  assign pready                 = s_q.ready;
  assign pslverr                = s_q.slverr;
  assign core_sleep_req         = s_q.dom_req[`DOM_CORE];
  assign bus_masters_sleep_req  = s_q.dom_req[`DOM_MASTERS];
  assign instr_buffer_sleep_req = s_q.dom_req[`DOM_IBUF];
  assign clockgen_sleep_req     = s_q.dom_req[`DOM_CLKGEN];
  assign ext_mem_if_sleep_o     = s_q.dom_req[`DOM_EXT_MEM_SLEEP_MASK];
  assign io_space_port_sleep_o  = s_q.dom_req[`DOM_IOPORT];
  assign master_port_sleep_o    = s_q.dom_req[`DOM_MASTER_PORT];
  assign fetch_port_sleep_o     = s_q.dom_req[`DOM_FPORT];
  assign unit_sleep_o           = s_q.unit_req;
  assign asleep_o               = (s_q.fsm == ST_ASLEEP);
  assign bus_error_o            = s_q.bus_err;

endmodule : idle_domain_power_control
`default_nettype wire

// file: bench/idle_power_props.sv
// Assertion checker for the idle power control block
`timescale 1ns/1ps
`default_nettype none
`include "idle_power_cfg.svh"

module idle_power_props #(
  parameter int ADDR_W = 18
) (
  input wire logic clk_i, reset_i, psel, penable, pwrite, pready, // Clock, reset, APB
  input wire logic [ADDR_W-1:0] paddr,  // APB address
  input wire logic [31:0]       prdata, // APB read data
  input wire logic idle_strobe_i, wake_i, bus_error_o, // Idle strobe, wake, refusal
  input wire logic core_stopped_i, masters_stopped_i, ibuf_stopped_i, // Acks
  input wire logic clkgen_stopped_i, ext_mem_sleep_mask_stopped_i, io_port_stopped_i, // Acks
  input wire logic master_port_stopped_i, fport_stopped_i, // Acks
  input wire logic [`MASK_WIDTH-1:0] unit_stopped_i, unit_sleep_o, // Unit acks, requests
  input wire logic core_sleep_req, bus_masters_sleep_req, instr_buffer_sleep_req, // Requests
  input wire logic clockgen_sleep_req, ext_mem_if_sleep_o, io_space_port_sleep_o, // Requests
  input wire logic master_port_sleep_o, fetch_port_sleep_o // Requests
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic       st_rd;
  logic       mk_rd;
  logic [8:0] ack_v;
  // Completed reads of status and mask, and the acks in status bit order
  assign st_rd = psel && penable && pready && !pwrite && paddr == ADDR_W'(`STATUS_IDX * 4);
  assign mk_rd = psel && penable && pready && !pwrite && paddr == ADDR_W'(`MASK_IDX * 4);
  assign ack_v = {fport_stopped_i, master_port_stopped_i, io_port_stopped_i, ext_mem_sleep_mask_stopped_i,
                  clkgen_stopped_i, |unit_stopped_i, ibuf_stopped_i, masters_stopped_i,
                  core_stopped_i};

  property p_st_rsv; st_rd |-> prdata[31:9] == 23'h0; endproperty
  a_st_rsv: assert property (p_st_rsv) else $error("status upper bits not zero");
  property p_mk_rsv; mk_rd |-> prdata[31:14] == 18'h0; endproperty
  a_mk_rsv: assert property (p_mk_rsv) else $error("mask upper bits not zero");
  property p_st_val; st_rd |-> prdata[8:0] == $past(ack_v, 2); endproperty
  a_st_val: assert property (p_st_val) else $error("status differs from acks");
  property p_req_dly; $rose(core_sleep_req) |-> $past(idle_strobe_i); endproperty
  a_req_dly: assert property (p_req_dly) else $error("core request without idle");
  property p_unit_chg; $changed(unit_sleep_o) |-> $past(idle_strobe_i); endproperty
  a_unit_chg: assert property (p_unit_chg) else $error("unit request moved alone");
  property p_berr; bus_error_o |-> $past(idle_strobe_i) && !core_sleep_req && !clockgen_sleep_req;
  endproperty
  a_berr: assert property (p_berr) else $error("bad refusal");
  property p_clk_all;
    clockgen_sleep_req |-> core_sleep_req && bus_masters_sleep_req && instr_buffer_sleep_req
      && ext_mem_if_sleep_o && io_space_port_sleep_o && master_port_sleep_o && fetch_port_sleep_o;
  endproperty
  a_clk_all: assert property (p_clk_all) else $error("clock stop without others");
  property p_wake; wake_i && core_sleep_req |=> !core_sleep_req && !instr_buffer_sleep_req;
  endproperty
  a_wake: assert property (p_wake) else $error("wake left requests");
endmodule : idle_power_props

bind idle_domain_power_control idle_power_props #(.ADDR_W(ADDR_W)) u_props (
  .clk_i(clk_i), .reset_i(reset_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .prdata(prdata), .idle_strobe_i(idle_strobe_i),
  .wake_i(wake_i), .bus_error_o(bus_error_o), .core_stopped_i(core_stopped_i),
  .masters_stopped_i(masters_stopped_i), .ibuf_stopped_i(ibuf_stopped_i),
  .clkgen_stopped_i(clkgen_stopped_i), .ext_mem_sleep_mask_stopped_i(ext_mem_sleep_mask_stopped_i),
  .io_port_stopped_i(io_port_stopped_i), .master_port_stopped_i(master_port_stopped_i),
  .fport_stopped_i(fport_stopped_i), .unit_stopped_i(unit_stopped_i),
  .unit_sleep_o(unit_sleep_o), .core_sleep_req(core_sleep_req),
  .bus_masters_sleep_req(bus_masters_sleep_req),
  .instr_buffer_sleep_req(instr_buffer_sleep_req),
  .clockgen_sleep_req(clockgen_sleep_req), .ext_mem_if_sleep_o(ext_mem_if_sleep_o),
  .io_space_port_sleep_o(io_space_port_sleep_o),
  .master_port_sleep_o(master_port_sleep_o), .fetch_port_sleep_o(fetch_port_sleep_o));
`default_nettype wire

// file: bench/idle_domain_power_control_tb_top.sv
// Self-checking testbench for the idle power control block
`timescale 1ns/1ps
`default_nettype none
`include "idle_power_cfg.svh"

module idle_domain_power_control_tb_top;
  localparam logic [17:0] A_CF = 18'(`CONFIG_IDX * 4);
  localparam logic [17:0] A_ST = 18'(`STATUS_IDX * 4);
  localparam logic [17:0] A_MK = 18'(`MASK_IDX * 4);
  logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr, strobe, wake_i;
  logic        asleep_o, berr, ce;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        c_rq, m_rq, i_rq, k_rq, e_rq, x_rq, p_rq, f_rq; // Domain requests
  logic        c_ak, m_ak, i_ak, k_ak, e_ak, x_ak, p_ak, f_ak; // Domain acks
  logic [13:0] u_rq, u_ak;
  logic [32:0] exp_q[$];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  idle_domain_power_control DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_strobe_i(strobe), .wake_i(wake_i),
    .core_stopped_i(c_ak), .masters_stopped_i(m_ak), .ibuf_stopped_i(i_ak),
    .clkgen_stopped_i(k_ak), .ext_mem_sleep_mask_stopped_i(e_ak), .io_port_stopped_i(x_ak),
    .master_port_stopped_i(p_ak), .fport_stopped_i(f_ak), .unit_stopped_i(u_ak),
    .core_sleep_req(c_rq), .bus_masters_sleep_req(m_rq), .instr_buffer_sleep_req(i_rq),
    .clockgen_sleep_req(k_rq), .ext_mem_if_sleep_o(e_rq), .io_space_port_sleep_o(x_rq),
    .master_port_sleep_o(p_rq), .fetch_port_sleep_o(f_rq), .unit_sleep_o(u_rq),
    .asleep_o(asleep_o), .bus_error_o(berr));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Every domain and unit acknowledges its request one cycle later
  always @(posedge clk_i) begin
    {c_ak, m_ak, i_ak, k_ak, e_ak, x_ak, p_ak, f_ak} <=
      {c_rq, m_rq, i_rq, k_rq, e_rq, x_rq, p_rq, f_rq};
    u_ak <= u_rq;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Completed reads are compared with the oldest noted expectation
  always @(posedge clk_i) begin
    if (psel && penable && pready && !pwrite) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Writes the configuration, then gives one idle strobe; err is the refusal seen after it
  task automatic sleep_cmd(input logic [31:0] cfg, output logic err);
    apb(1'b1, A_CF, cfg, 33'h0);
    @(posedge clk_i);
    strobe <= 1'b1;
    @(posedge clk_i);
    strobe <= 1'b0;
    #1 err = berr;
  endtask : sleep_cmd

  initial begin
    logic [31:0] d;
    logic [13:0] m;
    logic [31:0] cfgs[4];
    logic        e;
    cfgs = '{32'h1, 32'h2, 32'h4, 32'h3FF};
    {reset_i, psel, penable, pwrite, strobe, wake_i} = 6'h20;
    ce     = 1'b1;
    paddr  = 18'h0;
    pwdata = 32'h0;
    {c_ak, m_ak, i_ak, k_ak, e_ak, x_ak, p_ak, f_ak, u_ak} = 22'h0;
    void'($urandom(60));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    // Reset values, access kinds, unmapped place
    apb(1'b0, A_CF, 32'h0, 33'h0);
    apb(1'b0, A_MK, 32'h0, 33'h0);
    d = $urandom;
    m = d[13:0];
    apb(1'b1, A_MK, d, 33'h0);
    apb(1'b0, A_MK, 32'h0, {1'b0, 18'h0, m});
    apb(1'b1, A_ST, 32'hFFFFFFFF, 33'h0);
    apb(1'b0, A_ST, 32'h0, 33'h0);
    apb(1'b0, 18'h00010, 32'h0, {1'b1, 32'h0});
    $display("test registers done");
    // Clock generator stop without the other domains, or with them but without the external clock bit, is refused
    sleep_cmd(32'h100, e);
    check(33'(e), 33'h1);
    sleep_cmd(32'h1FF, e);
    check(33'(e), 33'h1);
    check(33'({c_rq, k_rq, i_rq}), 33'h0);
    $display("test refusal done");
    // Each domain stops, shows in status, and resumes on wake
    foreach (cfgs[i]) begin
      sleep_cmd(cfgs[i], e);
      check(33'(e), 33'h0);
      for (int n = 0; n < 50 && asleep_o !== 1'b1; n++) @(posedge clk_i);
      check(33'(asleep_o), 33'h1);
      apb(1'b0, A_ST, 32'h0,
          (cfgs[i] == 32'h3FF) ? 33'h1F7 | 33'({|m, 3'h0}) : 33'(cfgs[i]));
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      apb(1'b0, A_ST, 32'h0, 33'({cfgs[i][3] & |m, 3'h0}));
    end
    $display("test domains done");
    // Unit requests follow the mask, wake by clear mask bits, all wake on request clear
    repeat (2) begin
      d = $urandom;
      m = d[13:0];
      apb(1'b1, A_MK, d, 33'h0);
      sleep_cmd(32'h8, e);
      @(posedge clk_i);
      check(33'(u_rq), 33'(m));
      repeat (2) @(posedge clk_i);
      apb(1'b0, A_ST, 32'h0, 33'({|m, 3'h0}));
    end
    sleep_cmd(32'h0, e);
    @(posedge clk_i);
    check(33'(u_rq), 33'h0);
    $display("test units done");
    // Clock enable low freezes the sequencer, so a strobe given then is lost
    apb(1'b1, A_CF, 32'h8, 33'h0);
    @(posedge clk_i);
    ce     <= 1'b0;
    strobe <= 1'b1;
    @(posedge clk_i);
    strobe <= 1'b0;
    repeat (2) @(posedge clk_i);
    ce     <= 1'b1;
    @(posedge clk_i);
    check(33'(u_rq), 33'h0);
    $display("test enable done");
    conclude();
  end
endmodule : idle_domain_power_control_tb_top
`default_nettype wire
